// ---- core/arc_pkg.sv ----
package arc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and conversion limits, in peripheral clock states
  localparam int unsigned RES_W = 10;
  localparam int unsigned HI_W = 8;
  localparam int unsigned RES_PAD_W = 6;
  localparam int unsigned NUM_RES = 4;
  localparam int unsigned CH_IDX_W = 2;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned TIMER_W = 10;
  localparam int unsigned SLOW_STATES = 536;
  localparam int unsigned FAST_STATES = 266;

  ////////////////////////////////////////////////////////////////////////////
  // Byte offsets from the block base
  localparam logic [ADDR_W-1:0] OFS_RES_LAST = 5'h0E;
  localparam logic [ADDR_W-1:0] OFS_CSR = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_CR = 5'h12;
  localparam int unsigned ADDR_ODD_BIT = 0;
  localparam int unsigned ADDR_LO_BIT = 1;
  localparam int unsigned ADDR_IDX_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and fixed values
  localparam int unsigned CSR_FLAG = 7;
  localparam int unsigned CSR_IE = 6;
  localparam int unsigned CSR_START = 5;
  localparam int unsigned CSR_MULTI = 4;
  localparam int unsigned CSR_SPEED = 3;
  localparam int unsigned CSR_CH_HI = 2;
  localparam int unsigned CR_TRG_HI = 7;
  localparam int unsigned CR_TRG_LO = 6;
  localparam int unsigned CR_SCAN = 5;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] CR_RESET = 8'h07;
  localparam logic [1:0] CR_RSVD_ZERO = 2'h0;
  localparam logic [2:0] CR_RSVD_ONE = 3'h7;
  localparam logic [RES_PAD_W-1:0] RES_PAD = 6'h00;
  localparam logic [1:0] TRG_ENABLED = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ARC_ST_IDLE = 2'h1,
    ARC_ST_CONVERT = 2'h2
  } arc_fsm_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic dma;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } arc_bus_req_t;

  typedef struct packed {
    logic start;
    logic speed;
    logic [2:0] channel;
  } arc_core_req_t;

  typedef struct packed {
    logic done;
    logic [RES_W-1:0] result;
  } arc_core_rsp_t;

  typedef struct packed {
    arc_fsm_t fsm;
    logic flag;
    logic ie;
    logic start;
    logic multi;
    logic speed;
    logic [2:0] ch;
    logic [1:0] trge;
    logic scan;
    logic [NUM_RES-1:0][RES_W-1:0] res;
    logic [HI_W-1:0] temp;
    logic armed;
    logic [CH_IDX_W-1:0] idx;
    logic [2:0] chan;
    logic launch;
    logic [7:0] rdata;
  } arc_state_t;

  typedef struct packed {
    logic running;
    logic [TIMER_W-1:0] count;
  } arc_timer_state_t;

  typedef struct packed {
    logic prev;
  } arc_edge_state_t;

  localparam arc_state_t ARC_STATE_RST = '{fsm: ARC_ST_IDLE, default: '0};

endpackage : arc_pkg

// ---- core/arc_conv_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module arc_conv_timer #(
  parameter int unsigned SLOW_LIMIT = arc_pkg::SLOW_STATES,
  parameter int unsigned FAST_LIMIT = arc_pkg::FAST_STATES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic speed_i,
  output logic expire_o
);
  import arc_pkg::*;

  if (SLOW_LIMIT >= 2**TIMER_W || FAST_LIMIT < 2 || SLOW_LIMIT < 2) begin : g_chk
    $error("arc_conv_timer: limit out of range");
  end

  localparam logic [TIMER_W-1:0] SLOW_LOAD = TIMER_W'(SLOW_LIMIT - 1);
  localparam logic [TIMER_W-1:0] FAST_LOAD = TIMER_W'(FAST_LIMIT - 1);

  arc_timer_state_t q;
  arc_timer_state_t d;

  always_comb begin
    d = q;
    if (stop_i) begin
      d.running = 1'b0;
    end else if (start_i) begin
      d.running = 1'b1;
      d.count = speed_i ? FAST_LOAD : SLOW_LOAD;
    end else if (q.running) begin
      if (q.count == '0) begin
        d.running = 1'b0;
      end else begin
        d.count = q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire_o = q.running && (q.count == '0);

endmodule : arc_conv_timer

`default_nettype wire

// ---- core/arc_fall_detect.sv ----
`timescale 1ns/1ps
`default_nettype none

module arc_fall_detect (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  output logic fall_o
);
  import arc_pkg::*;

  arc_edge_state_t q;
  arc_edge_state_t d;

  always_comb begin
    d = q;
    d.prev = pin_i;
  end

  // Reset loads the idle high level, so a pin held low through reset gives one edge
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= '{prev: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign fall_o = q.prev && !pin_i;

endmodule : arc_fall_detect

`default_nettype wire

// ---- core/arc_register_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module arc_register_control #(
  parameter int unsigned SLOW_LIMIT = arc_pkg::SLOW_STATES,
  parameter int unsigned FAST_LIMIT = arc_pkg::FAST_STATES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic standby_i,
  input wire arc_pkg::arc_bus_req_t bus_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_trigger_pin_n_i,
  output arc_pkg::arc_core_req_t core_req_o,
  input wire arc_pkg::arc_core_rsp_t core_rsp_i,
  output logic conversion_end_irq_o
);
  import arc_pkg::*;

  if (FAST_LIMIT > SLOW_LIMIT) begin : g_chk
    $error("arc_register_control: fast limit above slow limit");
  end

  arc_state_t q;
  arc_state_t d;

  logic trig_fall;
  logic trig_hit;
  logic timer_expire;
  logic timer_stop;
  logic is_res;
  logic is_res_lo;
  logic is_csr;
  logic is_cr;
  logic csr_wr;
  logic [CH_IDX_W-1:0] rd_idx;
  logic [CH_IDX_W-1:0] dest_idx;
  logic [CH_IDX_W-1:0] next_idx;
  logic group_mode;
  logic scan_mode;
  logic last_chan;
  logic conv_end;
  logic conv_take;
  logic flag_set;
  logic [7:0] csr_byte;
  logic [7:0] cr_byte;
  logic [7:0] hi_byte_sel;
  logic [7:0] lo_byte_sel;
  logic [7:0] rd_mux;
  logic [RES_W-1:0] core_result;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  arc_fall_detect u_trig (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(ext_trigger_pin_n_i),
    .fall_o(trig_fall)
  );

  assign trig_hit = trig_fall && (q.trge == TRG_ENABLED);

  // Timer bounds each channel even if the core never answers
  arc_conv_timer #(
    .SLOW_LIMIT(SLOW_LIMIT),
    .FAST_LIMIT(FAST_LIMIT)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(q.launch),
    .stop_i(timer_stop),
    .speed_i(q.speed),
    .expire_o(timer_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read data

  assign is_res = (bus_req_i.addr <= OFS_RES_LAST)
                  && !bus_req_i.addr[ADDR_ODD_BIT];
  assign is_res_lo = is_res && bus_req_i.addr[ADDR_LO_BIT];
  assign is_csr = bus_req_i.addr == OFS_CSR;
  assign is_cr = bus_req_i.addr == OFS_CR;
  assign csr_wr = bus_req_i.wr && is_csr;
  assign rd_idx = bus_req_i.addr[ADDR_IDX_LSB +: CH_IDX_W];

  assign csr_byte = {q.flag, q.ie, q.start, q.multi, q.speed, q.ch};
  assign cr_byte = {q.trge, q.scan, CR_RSVD_ZERO, CR_RSVD_ONE};
  assign hi_byte_sel = q.res[rd_idx][RES_W-1 -: HI_W];
  assign lo_byte_sel = {q.res[rd_idx][RES_W-HI_W-1:0], RES_PAD};

  always_comb begin
    rd_mux = 8'h00;
    if (is_res_lo) begin
      rd_mux = q.temp;
    end else if (is_res) begin
      rd_mux = hi_byte_sel;
    end else if (is_csr) begin
      rd_mux = csr_byte;
    end else if (is_cr) begin
      rd_mux = cr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing terms

  assign group_mode = q.multi;
  assign scan_mode = q.multi && q.scan;
  assign last_chan = q.idx == q.ch[CH_IDX_W-1:0];
  assign dest_idx = group_mode ? q.idx : q.ch[CH_IDX_W-1:0];
  assign next_idx = last_chan ? '0 : CH_IDX_W'(q.idx + 2'h1);
  assign core_result = core_rsp_i.result;
  assign conv_end = (q.fsm == ARC_ST_CONVERT) && !q.launch
                    && (core_rsp_i.done || timer_expire);
  assign conv_take = conv_end && q.start;
  assign flag_set = conv_take && (!group_mode || last_chan);
  assign timer_stop = conv_end || standby_i
                      || ((q.fsm == ARC_ST_CONVERT) && !q.start);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.launch = 1'b0;

    if (bus_req_i.rd) begin
      d.rdata = rd_mux;
      if (is_res && !is_res_lo) begin
        d.temp = lo_byte_sel;
      end
      if (is_csr && q.flag) begin
        d.armed = 1'b1;
      end
      if (bus_req_i.dma && is_res) begin
        d.flag = 1'b0;
      end
    end

    if (csr_wr) begin
      d.ie = bus_req_i.wdata[CSR_IE];
      d.start = bus_req_i.wdata[CSR_START];
      d.multi = bus_req_i.wdata[CSR_MULTI];
      d.speed = bus_req_i.wdata[CSR_SPEED];
      d.ch = bus_req_i.wdata[CSR_CH_HI:0];
      d.armed = 1'b0;
      // A one written to the flag is dropped
      if (!bus_req_i.wdata[CSR_FLAG] && q.armed) begin
        d.flag = 1'b0;
      end
    end

    // Reserved bits of the trigger register are not stored
    if (bus_req_i.wr && is_cr) begin
      d.trge = bus_req_i.wdata[CR_TRG_HI:CR_TRG_LO];
      d.scan = bus_req_i.wdata[CR_SCAN];
    end

    case (q.fsm)
      ARC_ST_IDLE: begin
        if (q.start) begin
          d.idx = '0;
          d.chan = group_mode ? {q.ch[CSR_CH_HI], 2'h0} : q.ch;
          d.launch = 1'b1;
          d.fsm = ARC_ST_CONVERT;
        end
      end
      ARC_ST_CONVERT: begin
        if (!q.start) begin
          d.fsm = ARC_ST_IDLE;
        end else if (conv_end) begin
          d.res[dest_idx] = core_result;
          if (!group_mode || (last_chan && !scan_mode)) begin
            d.start = 1'b0;
            d.fsm = ARC_ST_IDLE;
          end else begin
            d.idx = next_idx;
            d.chan = {q.ch[CSR_CH_HI], next_idx};
            d.launch = 1'b1;
          end
        end
      end
      default: begin
        d = ARC_STATE_RST;
      end
    endcase

    // Hardware set wins over a clear in the same cycle
    if (flag_set) begin
      d.flag = 1'b1;
    end
    // Late trigger edge is kept, so a finishing conversion restarts
    if (trig_hit) begin
      d.start = 1'b1;
    end

    if (standby_i) begin
      d = ARC_STATE_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= ARC_STATE_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o = q.rdata;
  assign core_req_o = '{start: q.launch, speed: q.speed, channel: q.chan};
  assign conversion_end_irq_o = q.flag && q.ie;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [TIMER_W:0] conv_cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || q.launch || (q.fsm != ARC_ST_CONVERT)) begin
      conv_cnt_q <= '0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  default clocking chk_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_lo_pad_zero: assert property (
    bus_req_i.rd && is_res_lo |=> reg_rdata_o[RES_PAD_W-1:0] == RES_PAD
  ) else $error("low byte pad bits not zero");

  chk_temp_latch: assert property (
    bus_req_i.rd && is_res && !is_res_lo && !standby_i
    |=> q.temp == $past(lo_byte_sel) && reg_rdata_o == $past(hi_byte_sel)
  ) else $error("high byte read did not latch low byte");

  chk_result_route: assert property (
    conv_take && !standby_i
    |=> q.res[$past(dest_idx)] == $past(core_result)
  ) else $error("result stored in wrong register");

  chk_standby_clear: assert property (
    standby_i |=> q.res == '0 && csr_byte == CSR_RESET && cr_byte == CR_RESET
  ) else $error("standby did not clear registers");

  chk_flag_clear_seq: assert property (
    q.armed && csr_wr && !bus_req_i.wdata[CSR_FLAG] && !flag_set |=> !q.flag
  ) else $error("read then write zero did not clear flag");

  chk_flag_dma_clear: assert property (
    bus_req_i.rd && bus_req_i.dma && is_res && !flag_set |=> !q.flag
  ) else $error("dma result read did not clear flag");

  chk_flag_write_one: assert property (
    csr_wr && bus_req_i.wdata[CSR_FLAG] && q.flag |=> q.flag
  ) else $error("writing one changed the flag");

  chk_irq_gate: assert property (
    conversion_end_irq_o == (csr_byte[CSR_FLAG] && csr_byte[CSR_IE])
  ) else $error("interrupt request without enable and flag");

  chk_flag_set: assert property (
    flag_set && !standby_i |=> q.flag
  ) else $error("end of pass did not set the flag");

  chk_core_launch: assert property (
    (q.fsm == ARC_ST_IDLE) && q.start && !standby_i |=> core_req_o.start
  ) else $error("start bit did not launch the core");

  chk_single_done: assert property (
    conv_take && !group_mode && !trig_hit && !standby_i
    |=> !q.start && q.flag && q.fsm == ARC_ST_IDLE
  ) else $error("single conversion did not finish cleanly");

  chk_multi_done: assert property (
    conv_take && group_mode && !scan_mode && last_chan && !trig_hit
    && !standby_i |=> !q.start && q.flag
  ) else $error("multi pass did not stop after last channel");

  chk_scan_wrap: assert property (
    conv_take && scan_mode && last_chan && !csr_wr && !standby_i
    |=> q.start && q.launch && q.idx == '0 ##1 core_req_o.start == 1'b0
  ) else $error("scan pass did not restart at first channel");

  // Count is stale in launch and idle cycles, so only live cycles are bound
  chk_conv_bound: assert property (
    (q.fsm == ARC_ST_CONVERT) && !q.launch
    |-> conv_cnt_q < (q.speed ? FAST_LIMIT : SLOW_LIMIT)
  ) else $error("conversion exceeded its state limit");

  chk_trig_start: assert property (
    trig_hit && !standby_i |=> q.start
  ) else $error("enabled trigger edge did not set start");

  chk_trig_ignored: assert property (
    trig_fall && q.trge != TRG_ENABLED && !q.start && !csr_wr |=> !q.start
  ) else $error("disabled trigger edge set start");

  chk_cr_fixed: assert property (
    bus_req_i.rd && is_cr
    |=> reg_rdata_o[4:0] == {CR_RSVD_ZERO, CR_RSVD_ONE}
  ) else $error("trigger register reserved bits wrong");

  cov_single_done: cover property (conv_take && !group_mode);
  cov_scan_wrap: cover property (conv_take && scan_mode && last_chan);
  cov_trig_start: cover property (trig_hit && !q.start);
  cov_dma_clear: cover property (bus_req_i.rd && bus_req_i.dma && q.flag);
  cov_multi_done: cover property (conv_take && group_mode && !scan_mode
                                  && last_chan);

endmodule : arc_register_control

`default_nettype wire

// ---- test/arc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module arc_core_model (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] lat_i,
  input wire arc_pkg::arc_core_req_t core_req_i,
  output arc_pkg::arc_core_rsp_t core_rsp_o
);
  import arc_pkg::*;
  logic busy_q;
  logic done_q;
  logic [7:0] cnt_q;
  logic [RES_W-1:0] val_q;

  // The result encodes the channel so the bench sees where it landed
  always_ff @(posedge sys_clk_i) begin
    done_q <= 1'b0;
    if (!reset_n_i) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      val_q <= '0;
    end else if (core_req_i.start) begin
      busy_q <= 1'b1;
      cnt_q <= 8'h00;
      val_q <= {core_req_i.channel, ~core_req_i.channel, 4'hA};
    end else if (busy_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == lat_i) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  // Off the done cycle the bus shows the inverse, never a stale match
  assign core_rsp_o = {done_q, done_q ? val_q : ~val_q};
endmodule : arc_core_model

`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import arc_pkg::*;
  logic clk;
  logic rst_n;
  logic stby;
  logic trg_n;
  logic irq;
  logic [7:0] lat;
  logic [7:0] rdata;
  logic [7:0] d;
  arc_bus_req_t bus;
  arc_core_req_t creq;
  arc_core_rsp_t crsp;
  int n_errors;
  int n_tests;
  int c;

  // Short limits keep the timeout case quick
  arc_register_control #(.SLOW_LIMIT(20), .FAST_LIMIT(10))
    arc_register_control_inst (
    .sys_clk_i(clk), .reset_n_i(rst_n), .standby_i(stby),
    .bus_req_i(bus), .reg_rdata_o(rdata), .ext_trigger_pin_n_i(trg_n),
    .core_req_o(creq), .core_rsp_i(crsp), .conversion_end_irq_o(irq));

  arc_core_model arc_core_model_inst (
    .sys_clk_i(clk), .reset_n_i(rst_n), .lat_i(lat),
    .core_req_i(creq), .core_rsp_o(crsp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [15:0] s,
                       input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic rd(input logic [4:0] a, input logic dma,
                    output logic [7:0] v);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.dma <= dma;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    bus.dma <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic wait_flag(input int n);
    for (int i = 0; i < n; i++) begin
      rd(OFS_CSR, 1'b0, d);
      if (d[CSR_FLAG] === 1'b1) return;
    end
    check("flag wait", 16'h0000, 16'h0001);
    print_verdict();
  endtask : wait_flag

  task automatic rd16(input int i, output logic [15:0] v);
    rd(5'(4 * i), 1'b0, v[15:8]);
    rd(5'(4 * i + 2), 1'b0, v[7:0]);
  endtask : rd16

  task automatic check_res(input int i, input logic [2:0] ch);
    logic [9:0] e;
    logic [15:0] v;
    e = {ch, ~ch, 4'hA};
    rd16(i, v);
    check("result", v, {e[9:2], e[1:0], 6'h00});
  endtask : check_res

  task automatic starts(input int n);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1 if (creq.start === 1'b1) c++;
    end
  endtask : starts

  //////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    logic [15:0] v;
    rd(OFS_CSR, 1'b0, d);
    check("csr", d, 16'h0000);
    rd(OFS_CR, 1'b0, d);
    check("cr", d, 16'h0007);
    for (int i = 0; i < 4; i++) begin
      rd16(i, v);
      check("result zero", v, 16'h0000);
    end
    wr(OFS_CR, 8'hFF);
    rd(OFS_CR, 1'b0, d);
    check("cr fixed", d, 16'h00E7);
    wr(OFS_CR, 8'h00);
    rd(OFS_CR, 1'b0, d);
    check("cr fixed", d, 16'h0007);
  endtask : t_idle

  task automatic t_single();
    logic [7:0] w;
    for (int ch = 0; ch < 8; ch++) begin
      lat <= 8'(ch);
      w = {1'b0, ch[0], 2'h2, ch[1], 3'(ch)};
      wr(OFS_CSR, w);
      wait_flag(60);
      check("csr done", d, {w[7:6], 2'h0, w[3:0]} | 8'h80);
      check("irq", irq, ch[0]);
      check("core", creq[3:0], {ch[1], 3'(ch)});
      // A one is ignored and disarms, so the next zero needs a new read
      wr(OFS_CSR, d);
      wr(OFS_CSR, d & 8'h7F);
      rd(OFS_CSR, 1'b0, d);
      check("flag kept", d[CSR_FLAG], 1'b1);
      wr(OFS_CSR, d & 8'h7F);
      rd(OFS_CSR, 1'b0, d);
      check("flag cleared", d[CSR_FLAG], 1'b0);
      check("irq", irq, 1'b0);
      check_res(ch % 4, 3'(ch));
    end
    lat <= 8'h3C;
    wr(OFS_CSR, 8'h28);
    wait_flag(12);
    check("timeout", d, 16'h0088);
    wr(OFS_CSR, 8'h08);
    starts(70);
    check("late no start", c, 16'h0000);
    rd(OFS_CSR, 1'b0, d);
    check("late done", d, 16'h0008);
  endtask : t_single

  task automatic t_multi();
    lat <= 8'h02;
    wr(OFS_CSR, 8'h32);
    wait_flag(60);
    check("multi end", d, 16'h0092);
    wr(OFS_CSR, 8'h12);
    for (int i = 0; i < 3; i++) begin
      check_res(i, 3'(i));
    end
    check_res(3, 3'h7);
    wr(OFS_CR, 8'h27);
    wr(OFS_CSR, 8'h35);
    wait_flag(60);
    check("scan runs", d[CSR_START], 1'b1);
    starts(30);
    check("scan again", c > 1, 1'b1);
    wr(OFS_CSR, 8'h15);
    starts(40);
    check("scan stop", c, 16'h0000);
    check_res(0, 3'h4);
    check_res(1, 3'h5);
    wr(OFS_CR, 8'h07);
  endtask : t_multi

  task automatic t_trigger();
    // Read first so the write below also clears a flag left by the scan
    rd(OFS_CSR, 1'b0, d);
    wr(OFS_CSR, 8'h43);
    wr(OFS_CR, 8'h47);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      trg_n <= 1'b0;
      starts(20);
      check("trigger", c, 16'(k));
      @(posedge clk);
      trg_n <= 1'b1;
      if (k == 0) wr(OFS_CR, 8'hC7);
    end
    wait_flag(60);
    check("trig end", d, 16'h00C3);
    check("irq", irq, 1'b1);
    rd(5'h0C, 1'b1, d);
    rd(OFS_CSR, 1'b0, d);
    check("dma clear", d, 16'h0043);
    check("irq", irq, 1'b0);
    check_res(3, 3'h3);
  endtask : t_trigger

  task automatic t_standby();
    logic [15:0] v;
    lat <= 8'h3C;
    wr(OFS_CSR, 8'h68);
    starts(3);
    @(posedge clk);
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    starts(70);
    check("no restart", c, 16'h0000);
    rd(OFS_CSR, 1'b0, d);
    check("csr", d, 16'h0000);
    rd(OFS_CR, 1'b0, d);
    check("cr", d, 16'h0007);
    for (int i = 0; i < 4; i++) begin
      rd16(i, v);
      check("result zero", v, 16'h0000);
    end
  endtask : t_standby

  initial begin
    rst_n = 1'b0;
    stby = 1'b0;
    trg_n = 1'b1;
    lat = 8'h00;
    bus = '0;
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_idle();
    t_single();
    t_multi();
    t_trigger();
    t_standby();
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
